// ---- src/scwuc_pkg.sv ----
// Constants, register map and counter layout for the clock/SRAM write and update block.
// Assumes a single 100 MHz clock; shared by the top module and both helper modules.
package scwuc_pkg;
  localparam int          CLK_NS        = 10;
  localparam int          ADDR_W        = 15;
  localparam int          TIME_REGS     = 7;
  localparam logic [14:0] CLOCK_CONTROL = 15'h7FF8;   // Control byte, time bytes above it
  localparam logic [14:0] TIME_BASE     = 15'h7FF9;
  localparam int          SET_BIT       = 7;           // Set-time halt
  localparam int          READ_BIT      = 6;           // Halt-for-read
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  // Counter slots, in time-register order
  localparam int          I_SEC         = 0;
  localparam int          I_MIN         = 1;
  localparam int          I_HOUR        = 2;
  localparam int          I_DAY         = 3;
  localparam int          I_DATE        = 4;
  localparam int          I_MONTH       = 5;
  localparam int          I_YEAR        = 6;
  // Bits of each time byte owned by the counters; the rest stay software bits
  localparam logic [6:0][7:0] TIME_MASK = {8'hFF, 8'h1F, 8'h3F, 8'h07, 8'h3F, 8'h7F, 8'h7F};
  localparam logic [6:0][7:0] TIME_MAX  = {8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59};
  localparam logic [6:0][7:0] TIME_MIN  = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [6:0][7:0] TIME_INIT = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0]  MONTH_FEB     = 8'h02;
  localparam logic [7:0]  MONTH_APR     = 8'h04;
  localparam logic [7:0]  MONTH_JUN     = 8'h06;
  localparam logic [7:0]  MONTH_SEP     = 8'h09;
  localparam logic [7:0]  MONTH_NOV     = 8'h11;
  localparam logic [7:0]  DAYS_28       = 8'h28;
  localparam logic [7:0]  DAYS_29       = 8'h29;
  localparam logic [7:0]  DAYS_30       = 8'h30;
  // Timing
  localparam int          SECOND_NS     = 1_000_000_000;
  localparam int          SECOND_CYC    = SECOND_NS / CLK_NS;
  localparam int          TREC_NS       = 1_000;        // Power-up recovery interval
  localparam int          TREC_CYC      = (TREC_NS + CLK_NS - 1) / CLK_NS;
  localparam int          WLQZ_NS       = 25;           // Output release after write strobe
  localparam int          WLQZ_CYC      = (WLQZ_NS / CLK_NS) < 1 ? 1 : WLQZ_NS / CLK_NS;
endpackage : scwuc_pkg

// ---- src/scwuc_time_if.sv ----
// Carrier between the control logic and the internal time counters.
// Assumes both ends share clk_in.
`timescale 1ns/1ps
interface scwuc_time_if;
  logic [6:0][7:0] cnt;        // Live counter values
  logic            tick;       // One-cycle pulse, once per second
  logic            load;       // One-cycle pulse: copy load_val into counters
  logic [6:0][7:0] load_val;

  modport counter (output cnt, output tick, input load, input load_val);
  modport ctl     (input cnt, input tick, output load, output load_val);
endinterface : scwuc_time_if

// ---- src/scwuc_timecnt.sv ----
// Internal BCD time counters with a one-second divider.
// Assumes clk_in at 100 MHz; runs from reset whatever the supply state.
`timescale 1ns/1ps
module scwuc_timecnt #(
  parameter int TICK_CYCLES = scwuc_pkg::SECOND_CYC
) (
  input  wire logic      clk_in,
  input  wire logic      rstn_in,
  scwuc_time_if.counter  tif
);
  import scwuc_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYCLES + 1);

  logic [DIV_W-1:0] div_r, div_nxt;
  logic [6:0][7:0]  cnt_r, cnt_nxt;
  logic             tick_r, tick_nxt;

  // BCD increment of one byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // Last date of a month; leap year when the BCD year divides by four
  function automatic logic [7:0] last_date(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = (yr[4] ? (yr[1:0] == 2'h2) : (yr[1:0] == 2'h0)) && !yr[3] || (yr[3:0] == 4'h8 && !yr[4])
           || (yr[3:0] == 4'h6 && yr[4]);
    if (mon == MONTH_FEB) begin
      last_date = leap ? DAYS_29 : DAYS_28;
    end else if (mon == MONTH_APR || mon == MONTH_JUN || mon == MONTH_SEP || mon == MONTH_NOV) begin
      last_date = DAYS_30;
    end else begin
      last_date = TIME_MAX[I_DATE];
    end
  endfunction : last_date

  // Counting never waits on halts: only load or the divider touch it
  always_comb begin
    logic       carry;
    logic [7:0] top;
    carry    = 1'b0;
    top      = 8'h00;
    div_nxt  = div_r;
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (tif.load) begin
      div_nxt = '0;                                    // Restart the second on a new setting
      for (int i = 0; i < TIME_REGS; i++) begin
        cnt_nxt[i] = tif.load_val[i] & TIME_MASK[i];
      end
    end else if (div_r == DIV_W'(TICK_CYCLES - 1)) begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
      carry    = 1'b1;
      for (int i = 0; i < TIME_REGS; i++) begin
        top = (i == I_DATE) ? last_date(cnt_r[I_MONTH], cnt_r[I_YEAR]) : TIME_MAX[i];
        if (i == I_DAY) begin
          // Weekday rolls with the date, not into it
          if (carry) cnt_nxt[i] = (cnt_r[i] >= top) ? TIME_MIN[i] : bcd_inc(cnt_r[i]);
        end else if (carry) begin
          if (cnt_r[i] >= top) begin
            cnt_nxt[i] = TIME_MIN[i];
          end else begin
            cnt_nxt[i] = bcd_inc(cnt_r[i]);
            carry      = 1'b0;
          end
        end
      end
    end else begin
      div_nxt = div_r + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_r  <= '0;
      cnt_r  <= TIME_INIT;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tif.cnt  = cnt_r;
  assign tif.tick = tick_r;
endmodule : scwuc_timecnt

// ---- src/scwuc_pwrgate.sv ----
// Power-fail deselect and power-up recovery timer.
// Assumes power_good_in and on_backup_in come from an analog supply monitor, clock-synchronous.
`timescale 1ns/1ps
module scwuc_pwrgate #(
  parameter int TREC_CYCLES = scwuc_pkg::TREC_CYC
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic power_good_in,
  input  wire logic on_backup_in,
  output logic      bus_ok_out
);
  import scwuc_pkg::*;

  localparam int REC_W = $clog2(TREC_CYCLES + 1);

  logic [REC_W-1:0] rec_r, rec_nxt;
  logic             ok_r, ok_nxt;

  // Any dip restarts the whole recovery wait; protection is lifted only at its end
  always_comb begin
    rec_nxt = rec_r;
    ok_nxt  = ok_r;
    if (!power_good_in || on_backup_in) begin
      rec_nxt = '0;
      ok_nxt  = 1'b0;
    end else if (!ok_r) begin
      if (rec_r == REC_W'(TREC_CYCLES - 1)) begin
        ok_nxt = 1'b1;
      end else begin
        rec_nxt = rec_r + REC_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rec_r <= '0;
      ok_r  <= 1'b0;
    end else begin
      rec_r <= rec_nxt;
      ok_r  <= ok_nxt;
    end
  end

  assign bus_ok_out = ok_r && power_good_in && !on_backup_in;
endmodule : scwuc_pwrgate

// ---- src/scwuc_top.sv ----
// Byte-wide clock/SRAM port: write cycles, power-fail protection, time register update.
// Assumes bus strobes are already synchronous to clk_in; the host keeps the bus timing.
//
// Function
// - Write when write strobe and select low
// - Write spans last fall to first rise
// - Write strobe fall releases outputs within 25 ns
// - Simultaneous select and write: outputs stay off
// - Power fail: deselect, no writes, outputs off
// - Power fail mid-write only risks that byte
// - Backup keeps memory and counters running
// - Write protection holds through recovery interval
// - Time registers are copies; halting spares counters
// - Read bit one freezes time register updates
// - Halt captures time current at command
// - All time registers load together, uninterrupted
// - Updates resume within a second after clear
// - Set bit also freezes time register updates
// - Clearing set bit loads counters from registers
// - Next update within a second after set clear
// - Read when write strobe high, select low
// - Control and time bytes at top eight
`timescale 1ns/1ps
module scwuc_top #(
  parameter int TICK_CYCLES = scwuc_pkg::SECOND_CYC,
  parameter int TREC_CYCLES = scwuc_pkg::TREC_CYC
) (
  input  wire logic                         clk_in,
  input  wire logic                         rstn_in,
  input  wire logic [scwuc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [7:0]                   dq_in,
  output logic      [7:0]                   dq_out,
  output logic                              dq_oe_out,
  input  wire logic                         select_n_in,
  input  wire logic                         write_n_in,
  input  wire logic                         gate_n_in,
  input  wire logic                         power_good_in,
  input  wire logic                         on_backup_in,
  output logic                              bus_ok_out
);
  import scwuc_pkg::*;

  localparam int MEM_DEPTH = 2 ** ADDR_W;

  scwuc_time_if tif ();

  logic                  bus_ok;
  logic                  wr_act;
  logic                  wr_act_r, wr_act_nxt;
  logic [ADDR_W-1:0]     wr_addr_r, wr_addr_nxt;
  logic [7:0]            wr_data_r, wr_data_nxt;
  logic                  commit;
  logic [7:0]            mem_r [MEM_DEPTH];
  logic                  mem_we;
  logic [7:0]            ctl_r, ctl_nxt;
  logic [6:0][7:0]       time_r, time_nxt;
  logic                  load_r, load_nxt;
  logic [7:0]            rd_r, rd_nxt;
  logic                  halted;

  // Clock bytes sit in the top eight addresses; index 0 is the seconds byte, above the control byte
  function automatic logic is_clock(input logic [ADDR_W-1:0] a);
    is_clock = (a >= CLOCK_CONTROL);
  endfunction : is_clock

  function automatic logic [2:0] time_idx(input logic [ADDR_W-1:0] a);
    time_idx = 3'(a - TIME_BASE);
  endfunction : time_idx

  scwuc_timecnt #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timecnt (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .tif     (tif.counter)
  );

  scwuc_pwrgate #(
    .TREC_CYCLES (TREC_CYCLES)
  ) u_pwrgate (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .power_good_in (power_good_in),
    .on_backup_in  (on_backup_in),
    .bus_ok_out    (bus_ok)
  );

  // Write cycle is the overlap of both strobes; power fail drops it at once
  assign wr_act = bus_ok && !select_n_in && !write_n_in;

  // Track the cycle and keep the last sampled address and data
  always_comb begin
    wr_act_nxt  = wr_act;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    if (wr_act) begin
      wr_addr_nxt = addr_in;
      wr_data_nxt = dq_in;
    end
  end

  // Commit at the first strobe rise; a cycle cut by power loss is discarded, so
  // at worst the addressed byte misses its update and nothing else is touched
  assign commit = wr_act_r && !wr_act && bus_ok && (select_n_in || write_n_in);
  assign mem_we = commit && !is_clock(wr_addr_r);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_act_r  <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= 8'h00;
    end else begin
      wr_act_r  <= wr_act_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // Array keeps no reset so contents survive controller reset and backup
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem_r[wr_addr_r] <= wr_data_r;
    end
  end

  assign halted = ctl_r[SET_BIT] || ctl_r[READ_BIT];

  // Control byte, time register copies and counter load request
  always_comb begin
    logic       halt_now;
    logic [7:0] new_ctl;
    halt_now = 1'b0;
    new_ctl  = ctl_r;
    ctl_nxt  = ctl_r;
    time_nxt = time_r;
    load_nxt = 1'b0;
    if (commit && wr_addr_r == CLOCK_CONTROL) begin
      new_ctl  = wr_data_r;
      ctl_nxt  = wr_data_r;
      // A fresh halt snapshots the counters so reads see the commanded instant
      halt_now = !halted && (new_ctl[SET_BIT] || new_ctl[READ_BIT]);
      // Dropping the set bit pushes the edited registers into the counters
      load_nxt = ctl_r[SET_BIT] && !new_ctl[SET_BIT];
    end else if (commit && is_clock(wr_addr_r)) begin
      time_nxt[time_idx(wr_addr_r)] = wr_data_r;
    end
    // One cycle copies every byte, so no halt can split an update
    if ((tif.tick && !halted && !load_r) || halt_now) begin
      for (int i = 0; i < TIME_REGS; i++) begin
        time_nxt[i] = (time_r[i] & ~TIME_MASK[i]) | (tif.cnt[i] & TIME_MASK[i]);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl_r  <= CTL_RESET;
      time_r <= TIME_INIT;
      load_r <= 1'b0;
    end else begin
      ctl_r  <= ctl_nxt;
      time_r <= time_nxt;
      load_r <= load_nxt;
    end
  end

  // The counters restart their second on load, so the first update follows within it
  assign tif.load     = load_r;
  assign tif.load_val = time_r;

  // Read data is registered one cycle behind the address
  always_comb begin
    if (!is_clock(addr_in)) begin
      rd_nxt = mem_r[addr_in];
    end else if (addr_in == CLOCK_CONTROL) begin
      rd_nxt = ctl_r;
    end else begin
      rd_nxt = time_r[time_idx(addr_in)];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // Enable is combinational so a write strobe releases the pins in the same cycle,
  // well inside the release limit; with both strobes falling together it never rises
  assign dq_oe_out  = bus_ok && !select_n_in && !gate_n_in && write_n_in;
  assign dq_out     = rd_r;
  assign bus_ok_out = bus_ok;
endmodule : scwuc_top

// ---- tb/scwuc_monitor.sv ----
// Checker for the clock/SRAM port: output enable, power gating, write-back.
// Assumes it is bound into scwuc_top and sees only its ports.
`timescale 1ns/1ps
module scwuc_monitor #(
  parameter int TREC_CYCLES = 4
) (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [14:0] addr_in,
  input wire logic [7:0]  dq_in,
  input wire logic [7:0]  dq_out,
  input wire logic        dq_oe_out,
  input wire logic        select_n_in,
  input wire logic        write_n_in,
  input wire logic        gate_n_in,
  input wire logic        power_good_in,
  input wire logic        on_backup_in,
  input wire logic        bus_ok_out
);
  logic [7:0] pg_cnt_r;
  logic [7:0] pg_cnt_nxt;
  logic       act;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Clean-supply edge count, saturating so it never wraps back to zero
  always_comb begin
    pg_cnt_nxt = 8'h00;
    if (power_good_in && !on_backup_in) begin
      pg_cnt_nxt = (pg_cnt_r == 8'hFF) ? pg_cnt_r : pg_cnt_r + 8'h01;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) pg_cnt_r <= 8'h00;
    else pg_cnt_r <= pg_cnt_nxt;
  end
  assign act = bus_ok_out && !select_n_in && !write_n_in;
  // Output enable follows bus_ok_out, select, gate and strobe exactly
  property p_oe_eq;
    dq_oe_out == (bus_ok_out && !select_n_in && !gate_n_in && write_n_in);
  endproperty
  a_oe_eq: assert property (p_oe_eq) else $error("output enable mismatch");
  property p_wr_off;
    !write_n_in |-> !dq_oe_out;
  endproperty
  a_wr_off: assert property (p_wr_off) else $error("outputs on in write");
  property p_same_fall;
    $fell(select_n_in) && $fell(write_n_in) |-> !dq_oe_out;
  endproperty
  a_same_fall: assert property (p_same_fall) else $error("outputs driven on joint fall");
  property p_pf_off;
    !power_good_in |-> !bus_ok_out && !dq_oe_out;
  endproperty
  a_pf_off: assert property (p_pf_off) else $error("bus live in power fail");
  property p_backup;
    on_backup_in |-> !bus_ok_out;
  endproperty
  a_backup: assert property (p_backup) else $error("bus live on backup");
  property p_recover;
    bus_ok_out |-> pg_cnt_r >= 8'(TREC_CYCLES);
  endproperty
  a_recover: assert property (p_recover) else $error("bus opened early");
  // Bench runs with a recovery count of four edges
  property p_rec_hold;
    $rose(power_good_in) |-> !bus_ok_out [*4];
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("recovery too short");
  // Byte written is read back once the strobe is up and the address held
  property p_wr_back;
    act ##1 (!act && bus_ok_out && $stable(addr_in) && addr_in < 15'h7FF8)
    ##1 (bus_ok_out && $stable(addr_in)) |=> dq_out == $past(dq_in, 3);
  endproperty
  a_wr_back: assert property (p_wr_back) else $error("write not stored");
  c_write: cover property (act ##1 !act);
  c_ok: cover property ($rose(bus_ok_out));
  c_read: cover property (dq_oe_out);
endmodule : scwuc_monitor

bind scwuc_top scwuc_monitor #(.TREC_CYCLES(TREC_CYCLES)) u_scwuc_monitor (
  .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe_out(dq_oe_out), .select_n_in(select_n_in),
  .write_n_in(write_n_in), .gate_n_in(gate_n_in), .power_good_in(power_good_in),
  .on_backup_in(on_backup_in), .bus_ok_out(bus_ok_out));

// ---- tb/scwuc_host.sv ----
// Host processor model on the byte-wide asynchronous bus.
// Assumes strobes move only on falling clock edges.
`timescale 1ns/1ps
module scwuc_host (
  input  wire logic        clk_in,
  input  wire logic [7:0]  rdata_in,
  output logic      [14:0] addr_out,
  output logic      [7:0]  wdata_out,
  output logic             select_n_out,
  output logic             write_n_out,
  output logic             gate_n_out
);
  // Select parked high through power-up
  initial begin
    addr_out = 15'h0000;
    wdata_out = 8'h00;
    select_n_out = 1'b1;
    write_n_out = 1'b1;
    gate_n_out = 1'b1;
  end
  // Both strobes fall together; gate stays high to avoid contention
  task automatic wr_begin(input logic [14:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    select_n_out <= 1'b0;
    write_n_out <= 1'b0;
  endtask : wr_begin
  // Sixty ns held before the ending strobe; then one idle edge
  task automatic wr_end(input logic sel_end);
    repeat (6) @(negedge clk_in);
    if (sel_end) select_n_out <= 1'b1;
    else write_n_out <= 1'b1;
    @(negedge clk_in);
    select_n_out <= 1'b1;
    write_n_out <= 1'b1;
    wdata_out <= ~wdata_out;
    @(negedge clk_in);
  endtask : wr_end
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out <= a;
    select_n_out <= 1'b0;
    gate_n_out <= 1'b0;
    repeat (2) @(negedge clk_in);
    d = rdata_in;
    select_n_out <= 1'b1;
    gate_n_out <= 1'b1;
  endtask : rd
endmodule : scwuc_host

// ---- tb/sram_clock_write_and_update_ctrl_tb.sv ----
// Self-checking bench: RAM traffic, power fail, clock set and halt.
// Assumes short tick and recovery counts; host model drives the bus.
`timescale 1ns/1ps
module sram_clock_write_and_update_ctrl_tb;
  import scwuc_pkg::*;
  localparam int TICK = 20;
  localparam int TREC = 4;
  localparam logic [6:0][7:0] TSET = {8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h58};
  logic        clk_in, rstn_in, power_good_in, on_backup_in, bus_ok_out;
  logic        dq_oe_out, select_n_in, write_n_in, gate_n_in;
  logic [14:0] addr_in, a;
  logic [7:0]  dq_in, dq_out, d, v;
  logic [7:0]  mem [int];
  int          num_errors, tests_run, cycles, i;
  integer      seed;
  scwuc_top #(.TICK_CYCLES(TICK), .TREC_CYCLES(TREC)) u_scwuc_top (
    .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .select_n_in(select_n_in),
    .write_n_in(write_n_in), .gate_n_in(gate_n_in), .power_good_in(power_good_in),
    .on_backup_in(on_backup_in), .bus_ok_out(bus_ok_out));
  scwuc_host u_scwuc_host (.clk_in(clk_in), .rdata_in(dq_out), .addr_out(addr_in),
    .wdata_out(dq_in), .select_n_out(select_n_in), .write_n_out(write_n_in),
    .gate_n_out(gate_n_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [14:0] wa, input logic [7:0] wd, input logic se);
    u_scwuc_host.wr_begin(wa, wd);
    u_scwuc_host.wr_end(se);
  endtask : wr
  task automatic rchk(input logic [14:0] ra, input logic [7:0] exp);
    u_scwuc_host.rd(ra, v);
    chk(v, exp);
  endtask : rchk
  // Seconds after the halt window: counting must have gone on
  function automatic logic [7:0] sec_ran(input logic [7:0] s);
    return {7'h00, (s >= 8'h04 && s <= 8'h08)};
  endfunction : sec_ran
  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    seed = 32'hC0DEEB7F;
    rstn_in = 1'b0;
    power_good_in = 1'b1;
    on_backup_in = 1'b0;
    repeat (12) @(negedge clk_in);
    rstn_in = 1'b1;
    chk({7'h00, bus_ok_out}, 8'h00);
    repeat (TREC + 1) @(negedge clk_in);
    chk({7'h00, bus_ok_out}, 8'h01);
    rchk(CLOCK_CONTROL, CTL_RESET);
    rchk(15'h7FFC, 8'h01);
    // Random bytes plus the top plain location, both strobe endings
    for (i = 0; i < 12; i++) begin
      a = (i == 0) ? 15'h7FF7 : 15'($random(seed)) & 15'h3FFF;
      d = 8'($random(seed));
      wr(a, d, i[0]);
      mem[int'(a)] = d;
    end
    wr(15'h0100, 8'h11, 1'b0);
    wr(15'h0101, 8'h22, 1'b1);
    mem[32'h100] = 8'h11;
    mem[32'h101] = 8'h22;
    // Supply drops mid-write; the write and a later one are dropped
    u_scwuc_host.wr_begin(15'h0100, 8'hA5);
    repeat (2) @(negedge clk_in);
    power_good_in = 1'b0;
    on_backup_in = 1'b1;
    u_scwuc_host.wr_end(1'b0);
    wr(15'h0101, 8'h3C, 1'b0);
    chk({7'h00, bus_ok_out}, 8'h00);
    power_good_in = 1'b1;
    on_backup_in = 1'b0;
    repeat (TREC + 1) @(negedge clk_in);
    chk({7'h00, bus_ok_out}, 8'h01);
    rchk(15'h0100, 8'h11);
    foreach (mem[k]) rchk(15'(k), mem[k]);
    // Set two seconds before the end of a year, then let it roll over
    wr(CLOCK_CONTROL, 8'h80, 1'b0);
    for (i = 0; i < 7; i++) wr(TIME_BASE + 15'(i), TSET[i], 1'b0);
    wr(CLOCK_CONTROL, 8'h00, 1'b0);
    repeat (38) @(negedge clk_in);
    wr(CLOCK_CONTROL, 8'h40, 1'b0);
    for (i = 0; i < 7; i++) rchk(TIME_BASE + 15'(i), TIME_INIT[i]);
    rchk(CLOCK_CONTROL, 8'h40);
    repeat (3 * TICK) @(negedge clk_in);
    rchk(TIME_BASE, 8'h00);
    wr(CLOCK_CONTROL, 8'h00, 1'b0);
    repeat (TICK + 5) @(negedge clk_in);
    u_scwuc_host.rd(TIME_BASE, d);
    chk(sec_ran(d), 8'h01);
    end_of_test();
  end
endmodule : sram_clock_write_and_update_ctrl_tb
